// ===== dv/msr_sync_gen.sv
`timescale 1ns/100ps
`default_nettype none
module msr_sync_gen (
  // clock
  input  wire logic       clk,
  // shot control
  input  wire logic       start,
  input  wire logic [7:0] count,
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  // sync line
  output logic            sync_out,
  output logic            busy
);
  int i;

  initial begin
    sync_out = 1'b0;
    busy     = 1'b0;
  end

  // period hi_len+lo_len is picked by the bench to fit every mode
  always begin
    @(posedge clk);
    if (start) begin
      busy <= 1'b1;
      for (i = 0; i < count; i++) begin
        sync_out <= 1'b1;
        repeat (hi_len) @(posedge clk);
        sync_out <= 1'b0;
        repeat (lo_len) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== dv/msr_sync_receiver_test.sv
`timescale 1ns/100ps
`default_nettype none
module msr_sync_receiver_test
  import msr_pkg::*;
;
  logic        REF_CLK;
  logic        SYS_RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  wire logic   SYNC_IN;
  wire logic   gen_busy;
  logic        SAMPLING_ERROR_PIN;
  logic        SYNC_PULSE;
  logic        RDIV_TICK;
  logic [5:0]  RDIV_STATE;
  logic [3:0]  CLK_STATE;
  logic        go;
  logic [7:0]  cnt;
  logic [7:0]  hi;
  logic [7:0]  lo;
  logic [32:0] rd_q [$];
  logic [5:0]  pre_q [$];
  logic        exp_en;
  logic [5:0]  exp_pre;
  logic [5:0]  pe;
  logic [31:0] r;
  logic [3:0]  c;
  int          fails;
  int          total_checks;
  logic [5:0]  pre_t [5] = '{6'h00, 6'h01, 6'h05, 6'h14, 6'h03};
  logic [5:0]  rr_t [5]  = '{6'h0a, 6'h0a, 6'h0a, 6'h0a, 6'h01};
  logic [4:0]  dl_t [5]  = '{5'h00, 5'h1f, 5'h07, 5'h03, 5'h0c};

  msr_sync_receiver msr_sync_receiver_inst (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SYNC_IN(SYNC_IN),
    .SAMPLING_ERROR_PIN(SAMPLING_ERROR_PIN), .SYNC_PULSE(SYNC_PULSE),
    .RDIV_TICK(RDIV_TICK), .RDIV_STATE(RDIV_STATE), .CLK_STATE(CLK_STATE));

  msr_sync_gen msr_sync_gen_inst (
    .clk(REF_CLK), .start(go), .count(cnt), .hi_len(hi), .lo_len(lo),
    .sync_out(SYNC_IN), .busy(gen_busy));

  initial REF_CLK = 1'b0;
  always #20 REF_CLK = ~REF_CLK;

  task automatic test_done;
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [32:0] s, e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [5:0] clampv(input logic [5:0] p, m);
    logic [5:0] top;
    top = (m < 6'h02) ? 6'h02 : m;
    if (p < 6'h02) return 6'h02;
    return (p > top) ? top : p;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, a, d};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      test_done();
    end
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // lat of zero skips the latency comparison
  task automatic shot(input logic [7:0] k, h, l, input int lat);
    int n;
    int seen;
    seen = 0;
    @(posedge REF_CLK);
    {go, cnt, hi, lo} <= {1'b1, k, h, l};
    for (n = 1; n < 3000; n++) begin
      @(posedge REF_CLK);
      go <= 1'b0;
      #1;
      if (SYNC_PULSE === 1'b1 && seen == 0) seen = n;
      if (gen_busy === 1'b0) break;
    end
    if (n == 3000) begin
      fails++;
      test_done();
    end
    if (lat > 0) check("latency", 33'(seen), 33'(lat));
  endtask

  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      check("apb read", {PSLVERR, PRDATA}, rd_q.pop_front());
    end
  end

  always @(posedge SYNC_IN) begin
    if (exp_en === 1'b1) pre_q.push_back(exp_pre);
  end

  always @(posedge REF_CLK) begin
    if (SYNC_PULSE === 1'b1) begin
      #1;
      if (pre_q.size() == 0) begin
        check("stray pulse", 33'h1, 33'h0);
      end else begin
        pe = pre_q.pop_front();
        check("preset", 33'({RDIV_STATE, CLK_STATE}), 33'({pe, 4'h0}));
        check("pulse width", 33'(SYNC_PULSE), 33'h0);
        @(posedge REF_CLK);
        #1;
        check("free run", 33'(RDIV_STATE), 33'(pe - 6'h01));
        check("rate tick", 33'(RDIV_TICK), 33'(pe == 6'h02));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge REF_CLK);
    fails++;
    test_done();
  end

  initial begin
    {SYS_RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'h8, 8'h00, 32'h0};
    {go, cnt, hi, lo, exp_en, exp_pre} = '0;
    r = 32'h3c75;
    repeat (6) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    rd(MSR_OFS_CTRL, 33'h0);
    rd(MSR_OFS_SYNC, 33'h200);
    rd(MSR_OFS_INTERP, 33'h2);
    rd(8'h10, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      apb(1'b1, MSR_OFS_SYNC, r);
      rd(MSR_OFS_SYNC, 33'(r & 32'h000f3f1f));
      apb(1'b1, MSR_OFS_INTERP, r);
      rd(MSR_OFS_INTERP, 33'(r & 32'h0000003f));
    end
    apb(1'b1, MSR_OFS_CTRL, 32'h0);
    @(posedge REF_CLK);
    #1 c = CLK_STATE;
    @(posedge REF_CLK);
    #1 check("clock state", 33'(CLK_STATE), 33'(4'(c + 4'h1)));
    shot(8'h01, 8'h28, 8'h28, 0);
    apb(1'b1, MSR_OFS_CTRL, 32'h1);
    exp_en = 1'b1;
    for (int t = 0; t < 5; t++) begin
      apb(1'b1, MSR_OFS_INTERP, 32'(rr_t[t]));
      apb(1'b1, MSR_OFS_SYNC, {18'h0, pre_t[t], 3'h0, dl_t[t]});
      exp_pre = clampv(pre_t[t], rr_t[t]);
      shot(8'h01, 8'h28, 8'h28, int'(dl_t[t]) + 5);
    end
    // period 64 suits single tone, parallel and dual serial at R of 2
    shot(8'h04, 8'h20, 8'h20, 0);
    // window kept a small fraction of the sync period
    apb(1'b1, MSR_OFS_SYNC, 32'h00040202);
    apb(1'b1, MSR_OFS_CTRL, 32'h3);
    shot(8'h01, 8'h02, 8'h3c, 0);
    check("error pin", 33'(SAMPLING_ERROR_PIN), 33'h0);
    apb(1'b1, MSR_OFS_CTRL, 32'h1);
    shot(8'h01, 8'h02, 8'h3c, 0);
    check("error pin", 33'(SAMPLING_ERROR_PIN), 33'h1);
    apb(1'b1, MSR_OFS_CTRL, 32'h3);
    repeat (2) @(posedge REF_CLK);
    #1 check("error pin", 33'(SAMPLING_ERROR_PIN), 33'h0);
    apb(1'b1, MSR_OFS_CTRL, 32'h1);
    shot(8'h01, 8'h28, 8'h28, 0);
    check("error pin", 33'(SAMPLING_ERROR_PIN), 33'h0);
    shot(8'h01, 8'h02, 8'h3c, 0);
    check("error pin", 33'(SAMPLING_ERROR_PIN), 33'h1);
    exp_en = 1'b0;
    apb(1'b1, MSR_OFS_CTRL, 32'h0);
    repeat (2) @(posedge REF_CLK);
    #1 check("error pin", 33'(SAMPLING_ERROR_PIN), 33'h0);
    check("pending pulses", 33'(pre_q.size()), 33'h0);
    test_done();
  end
endmodule
`default_nettype wire

// ===== rtl/msr_pkg.sv
package msr_pkg;

  // apb register byte offsets
  localparam logic [7:0] MSR_OFS_CTRL   = 8'h00;
  localparam logic [7:0] MSR_OFS_SYNC   = 8'h04;
  localparam logic [7:0] MSR_OFS_INTERP = 8'h08;
  localparam logic [7:0] MSR_OFS_STATUS = 8'h0c;

  // control register fields
  localparam int MSR_CTRL_RX_EN_BIT   = 0;
  localparam int MSR_CTRL_VAL_DIS_BIT = 1;

  // multichip sync register fields
  localparam int MSR_SYNC_DLY_LSB   = 0;
  localparam int MSR_SYNC_DLY_W     = 5;
  localparam int MSR_SYNC_PRE_LSB   = 8;
  localparam int MSR_SYNC_PRE_W     = 6;
  localparam int MSR_SYNC_VDLY_LSB  = 16;
  localparam int MSR_SYNC_VDLY_W    = 4;

  // interpolation factor field
  localparam int MSR_INTERP_LSB = 0;
  localparam int MSR_INTERP_W   = 6;

  // status register fields
  localparam int MSR_STAT_ERR_BIT  = 0;
  localparam int MSR_STAT_SEEN_BIT = 1;
  localparam int MSR_STAT_CST_LSB  = 4;
  localparam int MSR_STAT_CST_W    = 4;
  localparam int MSR_STAT_RDIV_LSB = 8;

  // reset values
  localparam logic [5:0] MSR_RST_PRESET = 6'h02;
  localparam logic [5:0] MSR_RST_INTERP = 6'h02;
  localparam logic [4:0] MSR_RST_DLY    = 5'h00;
  localparam logic [3:0] MSR_RST_VDLY   = 4'h0;

  // clock generator
  localparam logic [5:0] MSR_PRESET_MIN   = 6'h02;
  localparam logic [3:0] MSR_CST_PRESET   = 4'h0;
  localparam logic [3:0] MSR_CST_STEP     = 4'h1;
  localparam logic [5:0] MSR_RDIV_STEP    = 6'h01;

  // timing: each delay tap is one 40 ns clock, the 150 ps analog delay step rounded up to whole clocks
  localparam int MSR_CLK_PERIOD_NS = 40;
  localparam int MSR_DLY_STEP_PS   = 150;
  localparam int MSR_TAP_CYCLES    =
    (MSR_DLY_STEP_PS + MSR_CLK_PERIOD_NS * 1000 - 1) /
    (MSR_CLK_PERIOD_NS * 1000);
  localparam int MSR_TAPS = 1 << MSR_SYNC_DLY_W;
  localparam int MSR_VTAPS = 1 << MSR_SYNC_VDLY_W;

  typedef struct packed {
    logic       rx_en;
    logic       val_dis;
    logic [4:0] rx_dly;
    logic [5:0] preset;
    logic [3:0] val_dly;
    logic [5:0] interp;
  } msr_cfg_s;

endpackage

// ===== rtl/msr_sync_receiver.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RL1: receiver works only while enable bit set
// RL2: clock generator always runs, enabled or not
// RL3: single tone: sync rate is clock over 4M
// RL4: parallel or dac mode: clock over 16(R+M)
// RL5: dual serial mode: clock over 32(R+M)
// RL6: every new rising edge re-presets clock state
// RL7: sync delayed by 5-bit programmable tap word
// RL8: sampled rising edge gives one-cycle pulse
// RL9: pulse loads rate divider with 6-bit preset
// RL10: preset lasts one cycle; other dividers preset too
// RL11: effective preset clamped to range 2 to R
// RL12: validation disable bit gates the checker
// RL13: 4-bit word skews the validation window
// RL14: latch disagreement stores one, drives error pin
// RL15: result latch held clear while receiver disabled
// RL16: write one then zero to arm each check
// RL17: keep validation delay a small clock fraction
// RL18: all chips get aligned sync, same settings
// RL19: no pulse or preset while receiver disabled
module msr_sync_receiver
  import msr_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // sync link
  input  wire logic        SYNC_IN,
  output logic             SAMPLING_ERROR_PIN,
  // clock generator state
  output logic             SYNC_PULSE,
  output logic             RDIV_TICK,
  output logic      [5:0]  RDIV_STATE,
  output logic      [3:0]  CLK_STATE
);

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == MSR_OFS_CTRL) || (a == MSR_OFS_SYNC) ||
               (a == MSR_OFS_INTERP) || (a == MSR_OFS_STATUS);
  endfunction

  function automatic logic [5:0] clamp_preset(input logic [5:0] v,
                                              input logic [5:0] r);
    logic [5:0] top;
    top = (r < MSR_PRESET_MIN) ? MSR_PRESET_MIN : r;
    if (v < MSR_PRESET_MIN) begin
      clamp_preset = MSR_PRESET_MIN;
    end else if (v > top) begin
      clamp_preset = top;
    end else begin
      clamp_preset = v;
    end
  endfunction

  msr_cfg_s   cfg_reg;
  logic       sync_meta_reg;
  logic       sync_lvl_reg;
  logic       tap_main;
  logic       tap_skew;
  logic       main_prev_reg;
  logic       rise;
  logic       sync_pulse_reg;
  logic       seen_reg;
  logic [5:0] rdiv_reg;
  logic [5:0] rdiv_next;
  logic [5:0] preset_eff;
  logic [5:0] r_eff;
  logic       rdiv_tick_reg;
  logic [3:0] cst_reg;
  logic       err_reg;
  logic       mismatch;
  logic       skew_prev_reg;
  logic [31:0] prdata_reg;
  logic       pready_reg;
  logic       pslverr_reg;
  logic       wr_take;
  logic       setup_ph;
  logic [31:0] rd_word;

  // apb: answer registered in setup, access lasts one cycle
  assign setup_ph = PSEL && !PENABLE;
  assign wr_take  = PSEL && PENABLE && pready_reg && PWRITE;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      MSR_OFS_CTRL: begin
        rd_word[MSR_CTRL_RX_EN_BIT]   = cfg_reg.rx_en;
        rd_word[MSR_CTRL_VAL_DIS_BIT] = cfg_reg.val_dis;
      end
      MSR_OFS_SYNC: begin
        rd_word[MSR_SYNC_DLY_LSB +: MSR_SYNC_DLY_W]   = cfg_reg.rx_dly;
        rd_word[MSR_SYNC_PRE_LSB +: MSR_SYNC_PRE_W]   = cfg_reg.preset;
        rd_word[MSR_SYNC_VDLY_LSB +: MSR_SYNC_VDLY_W] = cfg_reg.val_dly;
      end
      MSR_OFS_INTERP: begin
        rd_word[MSR_INTERP_LSB +: MSR_INTERP_W] = cfg_reg.interp;
      end
      MSR_OFS_STATUS: begin
        rd_word[MSR_STAT_ERR_BIT]  = err_reg;
        rd_word[MSR_STAT_SEEN_BIT] = seen_reg;
        rd_word[MSR_STAT_CST_LSB +: MSR_STAT_CST_W] = cst_reg;
        rd_word[MSR_STAT_RDIV_LSB +: MSR_INTERP_W]  = rdiv_reg;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      pready_reg  <= 1'b1;
      prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_word;
      pslverr_reg <= !addr_hit(PADDR);
    end else begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  // software configuration; status register is read only
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cfg_reg.rx_en   <= 1'b0;
      cfg_reg.val_dis <= 1'b0;
      cfg_reg.rx_dly  <= MSR_RST_DLY;
      cfg_reg.preset  <= MSR_RST_PRESET;
      cfg_reg.val_dly <= MSR_RST_VDLY;
      cfg_reg.interp  <= MSR_RST_INTERP;
    end else if (wr_take) begin
      case (PADDR)
        MSR_OFS_CTRL: begin
          cfg_reg.rx_en   <= PWDATA[MSR_CTRL_RX_EN_BIT]; // RL1
          cfg_reg.val_dis <= PWDATA[MSR_CTRL_VAL_DIS_BIT]; // RL12
        end
        MSR_OFS_SYNC: begin
          cfg_reg.rx_dly  <= PWDATA[MSR_SYNC_DLY_LSB +: MSR_SYNC_DLY_W];
          cfg_reg.preset  <= PWDATA[MSR_SYNC_PRE_LSB +: MSR_SYNC_PRE_W];
          cfg_reg.val_dly <= PWDATA[MSR_SYNC_VDLY_LSB +: MSR_SYNC_VDLY_W];
        end
        MSR_OFS_INTERP: begin
          cfg_reg.interp <= PWDATA[MSR_INTERP_LSB +: MSR_INTERP_W];
        end
        default: begin
          cfg_reg <= cfg_reg;
        end
      endcase
    end
  end

  // the pin is asynchronous to the local clock
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync_meta_reg <= 1'b0;
      sync_lvl_reg  <= 1'b0;
    end else begin
      sync_meta_reg <= SYNC_IN;
      sync_lvl_reg  <= sync_meta_reg;
    end
  end

  msr_tap_delay u_delay (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .din      (sync_lvl_reg),
    .dly      (cfg_reg.rx_dly),
    .vdly     (cfg_reg.val_dly),
    .tap_main (tap_main),
    .tap_skew (tap_skew)
  );

  // edge detector: rising edge of delayed sync, gated by enable
  assign rise = tap_main && !main_prev_reg;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      main_prev_reg  <= 1'b0;
      sync_pulse_reg <= 1'b0;
      skew_prev_reg  <= 1'b0;
    end else begin
      main_prev_reg  <= tap_main;
      skew_prev_reg  <= tap_skew;
      sync_pulse_reg <= rise && cfg_reg.rx_en; // RL8 RL19 RL6
    end
  end

  // sticky indication that a sync edge was taken since enable
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      seen_reg <= 1'b0;
    end else if (sync_pulse_reg) begin
      seen_reg <= 1'b1;
    end else if (!cfg_reg.rx_en) begin
      seen_reg <= 1'b0;
    end
  end

  // clock generator: rate divider counts down R_eff..1
  assign r_eff      = clamp_preset(cfg_reg.interp, cfg_reg.interp);
  assign preset_eff = clamp_preset(cfg_reg.preset, cfg_reg.interp); // RL11

  always_comb begin
    if (sync_pulse_reg) begin
      rdiv_next = preset_eff; // RL9 RL10
    end else if (rdiv_reg <= MSR_RDIV_STEP) begin
      rdiv_next = r_eff;
    end else begin
      rdiv_next = rdiv_reg - MSR_RDIV_STEP;
    end
  end

  // keeps running whatever the enable bit says
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdiv_reg      <= MSR_RST_INTERP;
      rdiv_tick_reg <= 1'b0;
    end else begin
      rdiv_reg      <= rdiv_next; // RL2
      rdiv_tick_reg <= (rdiv_next == MSR_RDIV_STEP);
    end
  end

  // common divider: preset alongside the rate divider for cadence
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cst_reg <= MSR_CST_PRESET;
    end else if (sync_pulse_reg) begin
      cst_reg <= MSR_CST_PRESET; // RL10
    end else begin
      cst_reg <= cst_reg + MSR_CST_STEP; // RL2
    end
  end

  // validation: main tap must still be high when the skew tap rises
  assign mismatch = tap_skew && !skew_prev_reg && (tap_main != tap_skew);

  // reset of the latch wins; a check needs the disable bit cycled
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      err_reg <= 1'b0;
    end else if (!cfg_reg.rx_en || cfg_reg.val_dis) begin
      err_reg <= 1'b0; // RL12 RL15 RL16
    end else if (mismatch) begin
      err_reg <= 1'b1; // RL14
    end
  end

  assign PRDATA             = prdata_reg;
  assign PREADY             = pready_reg;
  assign PSLVERR            = pslverr_reg;
  assign SAMPLING_ERROR_PIN = err_reg;
  assign SYNC_PULSE         = sync_pulse_reg;
  assign RDIV_TICK          = rdiv_tick_reg;
  assign RDIV_STATE         = rdiv_reg;
  assign CLK_STATE          = cst_reg;

  property p_no_pulse_off;
    @(posedge REF_CLK) disable iff (SYS_RST)
      sync_pulse_reg |-> $past(cfg_reg.rx_en);
  endproperty
  a_no_pulse_off: assert property (p_no_pulse_off) // RL19
    else $error("sync pulse while receiver disabled");

  property p_pulse_on_edge;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (rise && cfg_reg.rx_en) |=> sync_pulse_reg ##1 !sync_pulse_reg;
  endproperty
  a_pulse_on_edge: assert property (p_pulse_on_edge) // RL8
    else $error("edge did not give a one-cycle pulse");

  property p_preset_load;
    @(posedge REF_CLK) disable iff (SYS_RST)
      sync_pulse_reg |=> (rdiv_reg == $past(preset_eff)) &&
                         (cst_reg == MSR_CST_PRESET);
  endproperty
  a_preset_load: assert property (p_preset_load) // RL9
    else $error("dividers not preset by sync pulse");

  property p_clamp;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (preset_eff >= MSR_PRESET_MIN) && (preset_eff <= r_eff);
  endproperty
  a_clamp: assert property (p_clamp) // RL11
    else $error("preset outside 2 to R");

  property p_free_run;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (!sync_pulse_reg && rdiv_reg > MSR_RDIV_STEP) |=>
        (rdiv_reg == $past(rdiv_reg) - MSR_RDIV_STEP);
  endproperty
  a_free_run: assert property (p_free_run) // RL10
    else $error("rate divider did not count down");

  property p_cst_runs;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (!cfg_reg.rx_en && !sync_pulse_reg) |=>
        (cst_reg == $past(cst_reg) + MSR_CST_STEP);
  endproperty
  a_cst_runs: assert property (p_cst_runs) // RL2
    else $error("clock generator stalled while disabled");

  property p_err_off;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !cfg_reg.rx_en |=> !SAMPLING_ERROR_PIN;
  endproperty
  a_err_off: assert property (p_err_off) // RL15
    else $error("error pin high with receiver disabled");

  property p_err_held;
    @(posedge REF_CLK) disable iff (SYS_RST)
      cfg_reg.val_dis [*2] |-> !err_reg;
  endproperty
  a_err_held: assert property (p_err_held) // RL16
    else $error("result latch not held by disable bit");

  property p_err_set;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (cfg_reg.rx_en && !cfg_reg.val_dis && mismatch) |=>
        err_reg ##1 (err_reg || !cfg_reg.rx_en || cfg_reg.val_dis);
  endproperty
  a_err_set: assert property (p_err_set) // RL14
    else $error("mismatch not stored in result latch");

  property p_enable_gate;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !cfg_reg.rx_en [*2] |-> !sync_pulse_reg && !err_reg;
  endproperty
  a_enable_gate: assert property (p_enable_gate) // RL1
    else $error("receiver active while disabled");

endmodule
`default_nettype wire

// ===== rtl/msr_tap_delay.sv
`timescale 1ns/100ps
`default_nettype none
module msr_tap_delay
  import msr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // sampled sync level
  input  wire logic       din,
  // tap selection
  input  wire logic [4:0] dly,
  input  wire logic [3:0] vdly,
  // delayed outputs
  output logic            tap_main,
  output logic            tap_skew
);

  localparam int DEPTH = MSR_TAPS + MSR_VTAPS;

  logic [DEPTH-1:0] chain_reg;
  logic [5:0]       skew_idx;

  // tap zero is the registered input; a tap is one clock step
  always_ff @(posedge clk) begin
    if (rst) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[DEPTH-2:0], din}; // RL7
    end
  end

  assign skew_idx = 6'({1'b0, dly}) + 6'({2'b00, vdly});

  always_comb begin
    tap_main = chain_reg[dly]; // RL7
    tap_skew = chain_reg[skew_idx]; // RL13
  end

  property p_tap_zero;
    @(posedge clk) disable iff (rst)
      (dly == 5'h00) |-> (tap_main == $past(din));
  endproperty
  a_tap_zero: assert property (p_tap_zero) // RL7
    else $error("tap zero is not one step behind the input");

endmodule
`default_nettype wire
